// file: hw/asfc_map.vh
`ifndef ASFC_MAP_VH
`define ASFC_MAP_VH

// Register offsets
`define ASFC_OFS_LEVEL_LO 8'h0C
`define ASFC_OFS_LEVEL_HI 8'h0D
`define ASFC_OFS_DATA_LO 8'h0E
`define ASFC_OFS_DATA_HI 8'h0F
`define ASFC_OFS_STATUS 8'h10
`define ASFC_OFS_MASK 8'h11
`define ASFC_OFS_SETUP 8'h28
`define ASFC_OFS_COUNT_LO 8'h29
`define ASFC_OFS_POWER 8'h2D
`define ASFC_OFS_AUX_CTL 8'h3C
`define ASFC_OFS_TEMP_CTL 8'h3D

// Field positions
`define ASFC_SETUP_MODE_LSB 0
`define ASFC_SETUP_COUNT_MSB 2
`define ASFC_SETUP_CHAN_LSB 3
`define ASFC_POWER_MEASURE 1
`define ASFC_CONV_EN_BIT 0
`define ASFC_ST_WATERMARK 0
`define ASFC_ST_OVERRUN 1
`define ASFC_ST_TRIGGER 2

// Reset values
`define ASFC_SETUP_RST 8'h00
`define ASFC_COUNT_LO_RST 8'h80
`define ASFC_POWER_RST 8'h00
`define ASFC_CONV_RST 8'h00
`define ASFC_STATUS_RST 3'h0
`define ASFC_MASK_RST 3'h0

// Buffer modes
`define ASFC_MODE_OFF 2'h0
`define ASFC_MODE_OLDEST 2'h1
`define ASFC_MODE_STREAM 2'h2
`define ASFC_MODE_TRIG 2'h3

// Entry tags
`define ASFC_TAG_X 2'h0
`define ASFC_TAG_Y 2'h1
`define ASFC_TAG_Z 2'h2
`define ASFC_TAG_EXTRA 2'h3

`endif

// file: hw/asfc_sample_store.v
`timescale 1ns/1ps
`default_nettype none

module asfc_sample_store
#(
    parameter ENTRY_W = 16,
    parameter DEPTH = 512,
    parameter AW = 9
)
(
    input wire mclk,
    input wire rst_n,
    input wire flush,
    input wire push,
    input wire [ENTRY_W-1:0] pushData,
    input wire pop,
    output wire [ENTRY_W-1:0] headData,
    output reg [AW:0] level,
    output wire empty,
    output wire full
);

reg [ENTRY_W-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wrPtr;
reg [AW-1:0] rdPtr;

localparam [31:0] DEPTH_W = DEPTH;
localparam [31:0] LAST_W = DEPTH - 1;
localparam [AW:0] DEPTH_L = DEPTH_W[AW:0];
localparam [AW-1:0] LAST = LAST_W[AW-1:0];

assign empty = (level == {(AW+1){1'b0}});
assign full = (level == DEPTH_L);
assign headData = mem[rdPtr];

wire doPush = push && (!full || pop);
wire doPop = pop && !empty;

////////////////////////////////////////////////////////////////////////////////
always @(posedge mclk)
begin
    if (doPush)
    begin
        mem[wrPtr] <= pushData;
    end
end

always @(posedge mclk)
begin
    if (!rst_n || flush)
    begin
        wrPtr <= {AW{1'b0}};
        rdPtr <= {AW{1'b0}};
        level <= {(AW+1){1'b0}};
    end
    else
    begin
        if (doPush)
        begin
            wrPtr <= (wrPtr == LAST) ? {AW{1'b0}} : wrPtr + 1'b1;
        end
        if (doPop)
        begin
            rdPtr <= (rdPtr == LAST) ? {AW{1'b0}} : rdPtr + 1'b1;
        end
        if (doPush && !doPop)
        begin
            level <= level + 1'b1;
        end
        else if (doPop && !doPush)
        begin
            level <= level - 1'b1;
        end
    end
end

endmodule // asfc_sample_store

`default_nettype wire

// file: hw/asfc_top.v
// Summary of operation
// - Code 1000 stores x, y, z and aux
// - Codes 1001-1011 store one axis plus aux
// - Setup bit 2 is watermark count MSB
// - Threshold is count times channels per set
// - Oldest-saved mode stops writing when full
// - When full, accept only into freed space
// - Stream mode discards oldest for newest
// - Watermark event at threshold, interrupt if enabled
// - Triggered mode keeps pre-event sets, fires when full, re-arms after a host read
// - Code 0000 stores three axes, default
`include "asfc_map.vh"
`timescale 1ns/1ps
`default_nettype none

module asfc_top
#(
    parameter DEPTH = 512,
    parameter AW = 9,
    parameter DATA_W = 14
)
(
    input wire mclk,
    input wire rst_n,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata,
    input wire sampleValid,
    input wire [DATA_W-1:0] xData,
    input wire [DATA_W-1:0] yData,
    input wire [DATA_W-1:0] zData,
    input wire [DATA_W-1:0] tempData,
    input wire [DATA_W-1:0] auxData,
    input wire activityEvent,
    output wire irq,
    output reg levelEvent,
    output wire measureEnable,
    output wire auxConvEnable,
    output wire tempConvEnable
);

localparam ENTRY_W = DATA_W + 2;

////////////////////////////////////////////////////////////////////////////////
// Channel decode: {extra, z, y, x}
function [3:0] chanMask;
    input [3:0] code;
    input tempEn;
    input auxEn;
    begin
        case (code)
            4'h0: chanMask = 4'h7;
            4'h1: chanMask = 4'h1;
            4'h2: chanMask = 4'h2;
            4'h3: chanMask = 4'h4;
            4'h4: chanMask = {tempEn, 3'h7};
            4'h5: chanMask = {tempEn, 3'h1};
            4'h6: chanMask = {tempEn, 3'h2};
            4'h7: chanMask = {tempEn, 3'h4};
            4'h8: chanMask = {auxEn, 3'h7};
            4'h9: chanMask = {auxEn, 3'h1};
            4'hA: chanMask = {auxEn, 3'h2};
            4'hB: chanMask = {auxEn, 3'h4};
            // Reserved codes fall back to the safe default
            default: chanMask = 4'h7;
        endcase
    end
endfunction

function [2:0] maskCount;
    input [3:0] m;
    begin
        maskCount = {2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]};
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [7:0] setupReg;
reg [7:0] countLo;
reg [7:0] powerReg;
reg [7:0] auxCtl;
reg [7:0] tempCtl;
reg [2:0] status;
reg [2:0] mask;

wire [1:0] mode = setupReg[`ASFC_SETUP_MODE_LSB+1:`ASFC_SETUP_MODE_LSB];
wire [3:0] chanCode = setupReg[`ASFC_SETUP_CHAN_LSB+3:`ASFC_SETUP_CHAN_LSB];
wire [8:0] setCount = {setupReg[`ASFC_SETUP_COUNT_MSB], countLo};

assign measureEnable = powerReg[`ASFC_POWER_MEASURE];
assign auxConvEnable = auxCtl[`ASFC_CONV_EN_BIT];
assign tempConvEnable = tempCtl[`ASFC_CONV_EN_BIT];

wire [3:0] curMask = chanMask(chanCode, tempConvEnable, auxConvEnable);
wire [2:0] perSet = maskCount(curMask);
wire [11:0] threshold = {3'h0, setCount} * {9'h000, perSet};

wire wrSetup = regWr && (regAddr == `ASFC_OFS_SETUP);
// A mode change restarts the buffer so no half set survives
wire modeChange = wrSetup && (regWdata[`ASFC_SETUP_MODE_LSB+1:`ASFC_SETUP_MODE_LSB] != mode);
wire modeOff = (mode == `ASFC_MODE_OFF);
wire flush = modeChange || modeOff;

////////////////////////////////////////////////////////////////////////////////
// Buffer
wire [ENTRY_W-1:0] headData;
wire [AW:0] level;
// Fixed-width view so any depth with AW up to 15 fits the 16-bit level registers
wire [15:0] levelWide = {{(15-AW){1'b0}}, level};
wire bufEmpty;
wire bufFull;
reg [ENTRY_W-1:0] pushData;
wire push;
wire discard;
wire hostPop = regRd && (regAddr == `ASFC_OFS_DATA_HI) && !bufEmpty;

asfc_sample_store
#(
    .ENTRY_W(ENTRY_W),
    .DEPTH(DEPTH),
    .AW(AW)
)
u_store
(
    .mclk(mclk),
    .rst_n(rst_n),
    .flush(flush),
    .push(push),
    .pushData(pushData),
    .pop(hostPop || discard),
    .headData(headData),
    .level(level),
    .empty(bufEmpty),
    .full(bufFull)
);

////////////////////////////////////////////////////////////////////////////////
// Sample-set sequencer: one entry per cycle from the held set
reg [3:0] pend;
reg [DATA_W-1:0] holdX;
reg [DATA_W-1:0] holdY;
reg [DATA_W-1:0] holdZ;
reg [DATA_W-1:0] holdE;
reg [3:0] next_pend;

always @*
begin
    next_pend = pend;
    pushData = {ENTRY_W{1'b0}};
    if (pend[0])
    begin
        pushData = {`ASFC_TAG_X, holdX};
        next_pend[0] = 1'b0;
    end
    else if (pend[1])
    begin
        pushData = {`ASFC_TAG_Y, holdY};
        next_pend[1] = 1'b0;
    end
    else if (pend[2])
    begin
        pushData = {`ASFC_TAG_Z, holdZ};
        next_pend[2] = 1'b0;
    end
    else if (pend[3])
    begin
        pushData = {`ASFC_TAG_EXTRA, holdE};
        next_pend[3] = 1'b0;
    end
end

// A new set is only taken once the previous one is fully written
wire takeSet = sampleValid && measureEnable && !modeOff && (pend == 4'h0);
wire entryDue = (pend != 4'h0) && !flush;

always @(posedge mclk)
begin
    if (!rst_n || flush)
    begin
        pend <= 4'h0;
        holdX <= {DATA_W{1'b0}};
        holdY <= {DATA_W{1'b0}};
        holdZ <= {DATA_W{1'b0}};
        holdE <= {DATA_W{1'b0}};
    end
    else if (takeSet)
    begin
        pend <= curMask;
        holdX <= xData;
        holdY <= yData;
        holdZ <= zData;
        holdE <= chanCode[3] ? auxData : tempData;
    end
    else if (entryDue)
    begin
        pend <= next_pend;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Mode policy
reg trigSeen;
reg trigFired;
wire roomFree = !bufFull || hostPop;
wire preFull = (levelWide[11:0] >= threshold) && !bufEmpty;
reg pushOk;
reg discardReq;

always @*
begin
    pushOk = 1'b0;
    discardReq = 1'b0;
    case (mode)
        `ASFC_MODE_OLDEST:
        begin
            pushOk = roomFree;
        end
        `ASFC_MODE_STREAM:
        begin
            pushOk = 1'b1;
            discardReq = bufFull && !hostPop;
        end
        `ASFC_MODE_TRIG:
        begin
            if (trigSeen)
            begin
                pushOk = roomFree;
            end
            else
            begin
                // Pre-event window slides, keeping the newest sets
                pushOk = 1'b1;
                discardReq = (bufFull || preFull) && !hostPop;
            end
        end
        default:
        begin
            pushOk = 1'b0;
        end
    endcase
end

assign push = entryDue && pushOk;
assign discard = entryDue && discardReq;
wire overrun = (entryDue && !pushOk) || discard;

always @(posedge mclk)
begin
    if (!rst_n || flush)
    begin
        trigSeen <= 1'b0;
    end
    else if (mode == `ASFC_MODE_TRIG && measureEnable && activityEvent)
    begin
        trigSeen <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Watermark
reg levelEventQ;
reg trigPulse;
wire atThreshold = (levelWide[11:0] >= threshold);
wire trigReach = trigSeen && bufFull && !trigFired;

always @(posedge mclk)
begin
    if (!rst_n || flush)
    begin
        trigFired <= 1'b0;
        trigPulse <= 1'b0;
    end
    else
    begin
        trigPulse <= trigReach;
        if (trigReach)
        begin
            trigFired <= 1'b1;
        end
        else if (hostPop)
        begin
            // Re-arm only after the host has read something
            trigFired <= 1'b0;
        end
    end
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        levelEvent <= 1'b0;
        levelEventQ <= 1'b0;
    end
    else
    begin
        levelEventQ <= levelEvent;
        if (modeOff || modeChange)
        begin
            levelEvent <= 1'b0;
        end
        else if (mode == `ASFC_MODE_TRIG)
        begin
            levelEvent <= trigFired;
        end
        else
        begin
            levelEvent <= atThreshold;
        end
    end
end

wire wmEdge = (mode == `ASFC_MODE_TRIG) ? trigPulse : (levelEvent && !levelEventQ);

////////////////////////////////////////////////////////////////////////////////
// Status, mask and interrupt
wire [2:0] events;
assign events[`ASFC_ST_WATERMARK] = wmEdge;
assign events[`ASFC_ST_OVERRUN] = overrun;
assign events[`ASFC_ST_TRIGGER] = (mode == `ASFC_MODE_TRIG) && measureEnable && activityEvent && !trigSeen;

wire [2:0] clearBits = (regWr && regAddr == `ASFC_OFS_STATUS) ? regWdata[2:0] : 3'h0;

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        status <= `ASFC_STATUS_RST;
    end
    else
    begin
        // Set wins over a clear in the same cycle
        status <= (status & ~clearBits) | events;
    end
end

assign irq = |(status & mask);

////////////////////////////////////////////////////////////////////////////////
// Register writes
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        setupReg <= `ASFC_SETUP_RST;
        countLo <= `ASFC_COUNT_LO_RST;
        powerReg <= `ASFC_POWER_RST;
        auxCtl <= `ASFC_CONV_RST;
        tempCtl <= `ASFC_CONV_RST;
        mask <= `ASFC_MASK_RST;
    end
    else if (regWr)
    begin
        case (regAddr)
            `ASFC_OFS_SETUP: setupReg <= {1'b0, regWdata[6:0]};
            `ASFC_OFS_COUNT_LO: countLo <= regWdata;
            `ASFC_OFS_POWER: powerReg <= regWdata & 8'h02;
            `ASFC_OFS_AUX_CTL: auxCtl <= regWdata & 8'h01;
            `ASFC_OFS_TEMP_CTL: tempCtl <= regWdata & 8'h01;
            `ASFC_OFS_MASK: mask <= regWdata[2:0];
            default: mask <= mask;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register reads: data valid only in the cycle after the strobe
reg [7:0] readMux;

always @*
begin
    case (regAddr)
        `ASFC_OFS_LEVEL_LO: readMux = levelWide[7:0];
        `ASFC_OFS_LEVEL_HI: readMux = levelWide[15:8];
        `ASFC_OFS_DATA_LO: readMux = bufEmpty ? 8'h00 : headData[7:0];
        `ASFC_OFS_DATA_HI: readMux = bufEmpty ? 8'h00 : headData[ENTRY_W-1:8];
        `ASFC_OFS_STATUS: readMux = {5'h00, status};
        `ASFC_OFS_MASK: readMux = {5'h00, mask};
        `ASFC_OFS_SETUP: readMux = setupReg;
        `ASFC_OFS_COUNT_LO: readMux = countLo;
        `ASFC_OFS_POWER: readMux = powerReg;
        `ASFC_OFS_AUX_CTL: readMux = auxCtl;
        `ASFC_OFS_TEMP_CTL: readMux = tempCtl;
        default: readMux = 8'h00;
    endcase
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        regRdata <= 8'h00;
    end
    else if (regRd)
    begin
        regRdata <= readMux;
    end
    else
    begin
        regRdata <= 8'h00;
    end
end

endmodule // asfc_top

`default_nettype wire

// file: test/asfc_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "asfc_map.vh"
module asfc_checker
#(
    parameter DEPTH = 512,
    parameter AW = 9
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic sampleValid,
    input wire logic activityEvent,
    input wire logic irq,
    input wire logic levelEvent,
    input wire logic measureEnable,
    input wire logic auxConvEnable,
    input wire logic tempConvEnable
);
    logic [3:0] sinceHost;
    logic [3:0] sinceCause;
    logic maskZero;
    wire logic cfgWr = regWr && (regAddr == `ASFC_OFS_SETUP || regAddr == `ASFC_OFS_COUNT_LO);
    wire logic pop = regRd && regAddr == `ASFC_OFS_DATA_HI;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Saturating ages of the last cause that may move the level flag
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sinceHost <= 4'h0;
            sinceCause <= 4'h0;
            maskZero <= 1'b1;
        end
        else
        begin
            sinceHost <= (cfgWr || pop) ? 4'h0 : sinceHost + {3'h0, sinceHost != 4'hF};
            sinceCause <= (cfgWr || sampleValid || activityEvent) ? 4'h0 : sinceCause + {3'h0, sinceCause != 4'hF};
            if (regWr && regAddr == `ASFC_OFS_MASK)
                maskZero <= regWdata[2:0] == 3'h0;
        end
    end
    ////////////////////////////////////////
    sequence s_write_to(logic [7:0] a);
        regWr && regAddr == a;
    endsequence
    sequence s_setup_off;
        s_write_to(`ASFC_OFS_SETUP) ##0 regWdata[1:0] == `ASFC_MODE_OFF;
    endsequence
    a_rdata_idle: assert property (regRdata != 8'h00 |-> $past(regRd))
        else $error("read data outside a read answer");
    a_irq_masked: assert property (maskZero |-> !irq)
        else $error("irq with all sources masked");
    a_level_rise: assert property ($rose(levelEvent) |-> sinceCause < 4'hC)
        else $error("level flag rose with no sample or setup");
    a_level_hold: assert property ($fell(levelEvent) |-> sinceHost < 4'h4)
        else $error("level flag fell with no read or setup");
    a_off_quiet: assert property (s_setup_off |=> ##1 !levelEvent)
        else $error("level flag high with buffer off");
    a_aux_follow: assert property (s_write_to(`ASFC_OFS_AUX_CTL) |=> auxConvEnable == $past(regWdata[0]))
        else $error("aux enable not taken");
    a_temp_follow: assert property (s_write_to(`ASFC_OFS_TEMP_CTL) |=> tempConvEnable == $past(regWdata[0]))
        else $error("temp enable not taken");
    a_measure_follow: assert property (s_write_to(`ASFC_OFS_POWER) |=> measureEnable == $past(regWdata[1]))
        else $error("measure enable not taken");
endmodule // asfc_checker

bind asfc_top asfc_checker #(.DEPTH(DEPTH), .AW(AW)) asfc_checker_i
(
    .mclk(mclk),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .sampleValid(sampleValid),
    .activityEvent(activityEvent),
    .irq(irq),
    .levelEvent(levelEvent),
    .measureEnable(measureEnable),
    .auxConvEnable(auxConvEnable),
    .tempConvEnable(tempConvEnable)
);
`default_nettype wire

// file: test/asfc_sample_source.sv
`timescale 1ns/1ps
`default_nettype none
module asfc_sample_source
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic slow,
    input wire logic [7:0] base,
    output logic sampleValid,
    output logic [13:0] xData,
    output logic [13:0] yData,
    output logic [13:0] zData,
    output logic [13:0] tempData,
    output logic [13:0] auxData
);
    logic goLate;
    wire logic fire = slow ? goLate : go;
    // Outside a set the lines toggle, so stale data never looks valid
    always @(posedge mclk)
    begin
        goLate <= go;
        sampleValid <= rst_n && fire;
        xData <= fire ? {3'h0, base, 3'h1} : ~xData;
        yData <= fire ? {3'h0, base, 3'h2} : ~yData;
        zData <= fire ? {3'h0, base, 3'h3} : ~zData;
        tempData <= fire ? {3'h0, base, 3'h4} : ~tempData;
        auxData <= fire ? {3'h0, base, 3'h5} : ~auxData;
    end
endmodule // asfc_sample_source
`default_nettype wire

// file: test/asfc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "asfc_map.vh"
module asfc_top_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic act = 1'b0;
    logic [7:0] base = 8'h00;
    wire logic [7:0] regRdata;
    wire logic sampleValid, irq, levelEvent, measureEnable, auxConvEnable, tempConvEnable;
    wire logic [13:0] xData, yData, zData, tempData, auxData;
    int failCount = 0;
    int checked = 0;
    logic [7:0] lo;
    logic [7:0] hi;
    // Row: code, extra enable, entry count, tag sequence; codes stay below 1100
    localparam logic [15:0] ROWS [11] = '{16'h0318, 16'h8C1B, 16'h8318, 16'h9A30, 16'hAA70, 16'hBAB0,
        16'h1100, 16'h2140, 16'h3180, 16'h4C1B, 16'h7180};

    always #4 mclk = ~mclk;

    asfc_top #(.DEPTH(16), .AW(4)) asfc_top_i
    (
        .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .sampleValid(sampleValid), .xData(xData),
        .yData(yData), .zData(zData), .tempData(tempData), .auxData(auxData),
        .activityEvent(act), .irq(irq), .levelEvent(levelEvent), .measureEnable(measureEnable),
        .auxConvEnable(auxConvEnable), .tempConvEnable(tempConvEnable)
    );
    asfc_sample_source asfc_sample_source_i
    (
        .mclk(mclk), .rst_n(rst_n), .go(go), .slow(slow), .base(base), .sampleValid(sampleValid),
        .xData(xData), .yData(yData), .zData(zData), .tempData(tempData), .auxData(auxData)
    );
    ////////////////////////////////////////
    function automatic logic [15:0] ent(input logic [1:0] t, input logic [7:0] b, input logic tmp);
        ent = {t, 3'h0, b, (t == 2'h3) ? (tmp ? 3'h4 : 3'h5) : {1'b0, t} + 3'h1};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            failCount++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        rd(a, lo);
        chk({8'h00, lo}, {8'h00, exp});
    endtask
    task automatic entry(input logic [15:0] exp);
        rd(`ASFC_OFS_DATA_LO, lo);
        rd(`ASFC_OFS_DATA_HI, hi);
        chk({hi, lo}, exp);
    endtask
    // Sets stay well apart so none is dropped mid-write
    task automatic sset(input logic [7:0] b);
        @(posedge mclk);
        go <= 1'b1;
        base <= b;
        @(posedge mclk);
        go <= 1'b0;
        repeat (8) @(posedge mclk);
        #1;
    endtask
    task automatic cfg(input logic [7:0] s, input logic aux);
        wr(`ASFC_OFS_POWER, 8'h00);
        wr(`ASFC_OFS_SETUP, 8'h00);
        wr(`ASFC_OFS_AUX_CTL, {7'h00, aux});
        wr(`ASFC_OFS_TEMP_CTL, {7'h00, aux});
        wr(`ASFC_OFS_SETUP, s);
        wr(`ASFC_OFS_POWER, 8'h02);
    endtask
    task automatic conclude;
        $display("checked %0d failed %0d", checked, failCount);
        if (failCount == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge mclk);
        failCount++;
        conclude;
    end
    initial
    begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rdc(`ASFC_OFS_SETUP, 8'h00);
        rdc(`ASFC_OFS_COUNT_LO, 8'h80);
        rdc(8'hFF, 8'h00);
        chk({14'h0, levelEvent, irq}, 16'h0000);
        $display("reset done");
        for (int i = 0; i < 11; i++)
        begin
            cfg({1'b0, ROWS[i][15:12], 3'h2}, ROWS[i][11]);
            sset(8'(i + 16));
            rdc(`ASFC_OFS_LEVEL_LO, {5'h00, ROWS[i][10:8]});
            for (int j = 0; j < ROWS[i][10:8]; j++)
                entry(ent(ROWS[i][7 - 2 * j -: 2], 8'(i + 16), ROWS[i][15:14] == 2'b01));
            rdc(`ASFC_OFS_DATA_HI, 8'h00);
        end
        $display("channels done");
        cfg(8'h02, 1'b0);
        wr(`ASFC_OFS_COUNT_LO, 8'h02);
        sset(8'h01);
        chk({15'h0, levelEvent}, 16'h0000);
        sset(8'h02);
        chk({15'h0, levelEvent}, 16'h0001);
        rdc(`ASFC_OFS_STATUS, 8'h01);
        wr(`ASFC_OFS_MASK, 8'h01);
        chk({15'h0, irq}, 16'h0001);
        wr(`ASFC_OFS_MASK, 8'h00);
        chk({15'h0, irq}, 16'h0000);
        wr(`ASFC_OFS_MASK, 8'h01);
        wr(`ASFC_OFS_STATUS, 8'h01);
        chk({15'h0, irq}, 16'h0000);
        entry(ent(2'h0, 8'h01, 1'b0));
        repeat (2) @(posedge mclk);
        #1;
        chk({15'h0, levelEvent}, 16'h0000);
        $display("watermark done");
        slow <= 1'b1;
        cfg(8'h06, 1'b0);
        wr(`ASFC_OFS_COUNT_LO, 8'h00);
        rdc(`ASFC_OFS_SETUP, 8'h06);
        for (int k = 0; k < 6; k++)
            sset(8'(k));
        chk({15'h0, levelEvent}, 16'h0000);
        rdc(`ASFC_OFS_LEVEL_LO, 8'h10);
        rdc(`ASFC_OFS_STATUS, 8'h02);
        entry(ent(2'h2, 8'h00, 1'b0));
        $display("stream done");
        wr(`ASFC_OFS_STATUS, 8'h07);
        cfg(8'h01, 1'b0);
        for (int k = 0; k < 6; k++)
            sset(8'(k));
        rdc(`ASFC_OFS_LEVEL_LO, 8'h10);
        entry(ent(2'h0, 8'h00, 1'b0));
        sset(8'h09);
        rdc(`ASFC_OFS_LEVEL_LO, 8'h10);
        entry(ent(2'h1, 8'h00, 1'b0));
        $display("oldest done");
        // Pre-event window of one set, then fill to full after the trigger
        cfg(8'h03, 1'b0);
        wr(`ASFC_OFS_COUNT_LO, 8'h01);
        wr(`ASFC_OFS_STATUS, 8'h07);
        sset(8'h01);
        sset(8'h02);
        rdc(`ASFC_OFS_LEVEL_LO, 8'h03);
        @(posedge mclk);
        act <= 1'b1;
        @(posedge mclk);
        act <= 1'b0;
        for (int k = 3; k < 8; k++)
            sset(8'(k));
        rdc(`ASFC_OFS_LEVEL_LO, 8'h10);
        chk({15'h0, levelEvent}, 16'h0001);
        rdc(`ASFC_OFS_STATUS, 8'h07);
        entry(ent(2'h0, 8'h02, 1'b0));
        repeat (2) @(posedge mclk);
        #1;
        chk({15'h0, levelEvent}, 16'h0000);
        wr(`ASFC_OFS_STATUS, 8'h07);
        sset(8'h08);
        rdc(`ASFC_OFS_STATUS, 8'h03);
        $display("trigger done");
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rdc(`ASFC_OFS_SETUP, 8'h00);
        rdc(`ASFC_OFS_COUNT_LO, 8'h80);
        rdc(`ASFC_OFS_LEVEL_LO, 8'h00);
        rdc(`ASFC_OFS_STATUS, 8'h00);
        chk({14'h0, levelEvent, irq}, 16'h0000);
        $display("second reset done");
        conclude;
    end
endmodule // asfc_top_test
`default_nettype wire
